// File: logic/sfe_defines.svh
// Purpose: constants for the scan front end
// Assumes: 16-bit serial words, control word address nibble zero
// Notes: control bit positions are local choices
`ifndef SFE_DEFINES_SVH
`define SFE_DEFINES_SVH
`define SFE_WORD_BITS      16
`define SFE_ADDR_MSB       15
`define SFE_ADDR_LSB       12
`define SFE_ADDR_CTRL      4'h0
`define SFE_CTRL_MSB       11
`define SFE_BIT_AUTO_INC   0
`define SFE_BIT_SYNC_SEL   1
`define SFE_BIT_SYNC_EN    2
`define SFE_BIT_SIGN_EN    3
`define SFE_CTRL_RESET     12'h000
`define SFE_FREQ_RESET     24'h000000
`define SFE_FREQ_W         24
`define SFE_PHASE_W        24
`define SFE_DAC_MID        10'h200
`define SFE_DAC_W          10
`endif

// File: logic/sfe_pkg.sv
// Purpose: shared types for the scan front end
// Assumes: sfe_defines.svh holds the numbers
// Notes: none
`include "sfe_defines.svh"
package sfe_pkg;
	typedef struct packed {
		logic sign_pin_enable;
		logic sync_pin_enable;
		logic sync_select;
		logic auto_inc;
	} sfe_ctrl_t;
	typedef enum logic [1:0] {
		SFE_IDLE = 2'b00,
		SFE_RUN  = 2'b01,
		SFE_DONE = 2'b10
	} sfe_state_t;
endpackage : sfe_pkg

// File: logic/sfe_serial_rx.sv
// Purpose: link-clock shifter for 16-bit serial words, handed over by toggle
// Assumes: shift clock only runs inside frames
// Notes: word register is stable while the toggle crosses
`timescale 1ns/1ps
`default_nettype none
`include "sfe_defines.svh"
module sfe_serial_rx (
	input  wire logic                        sclk,
	input  wire logic                        rst_n,
	input  wire logic                        frame_sync_n,
	input  wire logic                        serial_data_in,
	output logic [`SFE_WORD_BITS-1:0]        word_reg,
	output logic                             word_tgl_reg
);
	logic [`SFE_WORD_BITS-2:0] shift_reg;
	logic [3:0]                count_reg;
	wire                       last_bit = (count_reg == 4'hF);
	// Frame sync high resets the bit count asynchronously so each frame starts fresh
	wire                       cnt_rst_n = rst_n & ~frame_sync_n;
	always_ff @(negedge sclk or negedge cnt_rst_n) begin
		if (!cnt_rst_n) begin
			count_reg <= 4'h0;
			shift_reg <= '0;
		end else begin
			count_reg <= count_reg + 4'h1;
			shift_reg <= {shift_reg[`SFE_WORD_BITS-3:0], serial_data_in};
		end
	end
	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			word_reg     <= '0;
			word_tgl_reg <= 1'b0;
		end else if (!frame_sync_n && last_bit) begin
			word_reg     <= {shift_reg, serial_data_in};
			word_tgl_reg <= ~word_tgl_reg;
		end
	end
endmodule : sfe_serial_rx
`default_nettype wire

// File: logic/sfe_top.sv
// Purpose: scan trigger, abort, standby and serial front end of a scan generator
// Assumes: host keeps frame timing; control pins asynchronous to CLK_SYS
// Notes: frequency words beyond the control register are ports
// Notes on behaviour
// - 16-bit words, address first, MSB first
// - Capture serial data on shift clock fall
// - Low frame sync starts word loading
// - Trigger rise initialises and starts scan
// - Auto mode: one pulse runs whole scan
// - External mode: one step per trigger rise
// - Abort rise resets scan state machines
// - After abort, DAC code goes midscale
// - Sync output: end of scan or step
// - Sync output only when enabled
// - Sign output is inverted DAC MSB
// - Sign output only when enabled
// - Standby gates internal clock and powers down; here the clock runs and an enable freezes the scan
// - Output frequency is clock times fraction
// - Consecutive 16-bit groups are separate words
// - Top nibble zero writes control register
// - Control write resets scan, DAC midscale
// - Hold last frequency after final step
`timescale 1ns/1ps
`default_nettype none
`include "sfe_defines.svh"
module sfe_top #(
	parameter int INTERVAL_W = 16
) (
	input  wire logic                        CLK_SYS,
	input  wire logic                        RST_N,
	input  wire logic                        SCLK_LINK,
	input  wire logic                        FRAME_SYNC_N,
	input  wire logic                        SERIAL_DATA_IN,
	input  wire logic                        SCAN_TRIGGER,
	input  wire logic                        SCAN_ABORT,
	input  wire logic                        STANDBY,
	input  wire logic [`SFE_FREQ_W-1:0]      START_FREQ,
	input  wire logic [`SFE_FREQ_W-1:0]      DELTA_FREQ,
	input  wire logic [11:0]                 NUM_INCR,
	input  wire logic [INTERVAL_W-1:0]       INTERVAL_CYCLES,
	output logic                             SCAN_SYNC_OUT,
	output logic                             SIGN_BIT_OUT,
	output logic [`SFE_DAC_W-1:0]            ANALOG_OUT,
	output logic                             POWER_DOWN,
	output logic [`SFE_CTRL_MSB:0]           CTRL_WORD,
	output logic [1:0]                       SCAN_STATE
);
	logic [`SFE_WORD_BITS-1:0] rx_word;
	logic                      rx_tgl;
	sfe_serial_rx u_rx (
		.sclk           (SCLK_LINK),
		.rst_n          (RST_N),
		.frame_sync_n   (FRAME_SYNC_N),
		.serial_data_in (SERIAL_DATA_IN),
		.word_reg       (rx_word),
		.word_tgl_reg   (rx_tgl)
	);

	// Three-stage synchronisers; stage 1 feeds only stage 2
	logic [2:0] tgl_sync_reg;
	logic [2:0] trig_sync_reg;
	logic [2:0] abort_sync_reg;
	logic [2:0] stby_sync_reg;
	logic       trig_lvl_reg;
	logic       abort_lvl_reg;
	logic       stby_lvl_reg;
	logic       tgl_seen_reg;
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			tgl_sync_reg   <= 3'h0;
			trig_sync_reg  <= 3'h0;
			abort_sync_reg <= 3'h0;
			stby_sync_reg  <= 3'h0;
		end else begin
			tgl_sync_reg   <= {tgl_sync_reg[1:0], rx_tgl};
			trig_sync_reg  <= {trig_sync_reg[1:0], SCAN_TRIGGER};
			abort_sync_reg <= {abort_sync_reg[1:0], SCAN_ABORT};
			stby_sync_reg  <= {stby_sync_reg[1:0], STANDBY};
		end
	end

	// A level counts only once stages two and three agree
	wire trig_agree  = trig_sync_reg[1] == trig_sync_reg[2];
	wire abort_agree = abort_sync_reg[1] == abort_sync_reg[2];
	wire stby_agree  = stby_sync_reg[1] == stby_sync_reg[2];
	wire tgl_agree   = tgl_sync_reg[1] == tgl_sync_reg[2];
	wire trig_lvl_next  = trig_agree ? trig_sync_reg[2] : trig_lvl_reg;
	wire abort_lvl_next = abort_agree ? abort_sync_reg[2] : abort_lvl_reg;
	wire stby_lvl_next  = stby_agree ? stby_sync_reg[2] : stby_lvl_reg;
	wire trig_rise  = trig_lvl_next & ~trig_lvl_reg;
	wire abort_rise = abort_lvl_next & ~abort_lvl_reg;
	wire word_new   = tgl_agree && (tgl_sync_reg[2] != tgl_seen_reg);
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			trig_lvl_reg  <= 1'b0;
			abort_lvl_reg <= 1'b0;
			stby_lvl_reg  <= 1'b0;
			tgl_seen_reg  <= 1'b0;
		end else begin
			trig_lvl_reg  <= trig_lvl_next;
			abort_lvl_reg <= abort_lvl_next;
			stby_lvl_reg  <= stby_lvl_next;
			tgl_seen_reg  <= word_new ? tgl_sync_reg[2] : tgl_seen_reg;
		end
	end

	// Control register decode
	function automatic logic is_ctrl_addr(input logic [`SFE_WORD_BITS-1:0] w);
		is_ctrl_addr = (w[`SFE_ADDR_MSB:`SFE_ADDR_LSB] == `SFE_ADDR_CTRL);
	endfunction : is_ctrl_addr
	logic [`SFE_CTRL_MSB:0] ctrl_reg;
	wire                    ctrl_wr = word_new && is_ctrl_addr(rx_word);
	wire [`SFE_CTRL_MSB:0]  ctrl_next = ctrl_wr ? rx_word[`SFE_CTRL_MSB:0] : ctrl_reg;
	sfe_pkg::sfe_ctrl_t     ctrl;
	assign ctrl.auto_inc        = ctrl_reg[`SFE_BIT_AUTO_INC];
	assign ctrl.sync_select     = ctrl_reg[`SFE_BIT_SYNC_SEL];
	assign ctrl.sync_pin_enable = ctrl_reg[`SFE_BIT_SYNC_EN];
	assign ctrl.sign_pin_enable = ctrl_reg[`SFE_BIT_SIGN_EN];

	// Standby freezes the scan logic except abort and control writes: a synchronous stand-in for the gated clock
	// Freeze from the cycle the filtered level rises, so the registered outputs hold one cycle ahead of POWER_DOWN
	wire run_en    = ~stby_lvl_next;
	wire scan_kill = abort_rise | ctrl_wr;

	sfe_pkg::sfe_state_t    state_reg;
	sfe_pkg::sfe_state_t    state_next;
	logic [`SFE_FREQ_W-1:0] freq_reg;
	logic [11:0]            step_reg;
	logic [INTERVAL_W-1:0]  tmr_reg;
	logic [`SFE_PHASE_W-1:0] phase_reg;
	logic                   active_reg;
	wire tmr_done   = (tmr_reg == '0);
	wire step_evt_a = ctrl.auto_inc && tmr_done;
	wire step_evt_e = !ctrl.auto_inc && trig_rise;
	wire step_evt   = (state_reg == sfe_pkg::SFE_RUN) && (step_evt_a || step_evt_e) && run_en;
	wire last_step  = (step_reg == NUM_INCR);
	wire do_step    = step_evt && !last_step;
	wire do_finish  = step_evt && last_step;
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sfe_pkg::SFE_IDLE: begin
				if (trig_rise && run_en) begin
					state_next = sfe_pkg::SFE_RUN;
				end
			end
			sfe_pkg::SFE_RUN: begin
				if (do_finish) begin
					state_next = sfe_pkg::SFE_DONE;
				end
			end
			sfe_pkg::SFE_DONE: begin
				state_next = sfe_pkg::SFE_DONE;
			end
			default: begin
				state_next = sfe_pkg::SFE_IDLE;
			end
		endcase
		if (scan_kill) begin
			state_next = sfe_pkg::SFE_IDLE;
		end
	end
	wire start = (state_reg == sfe_pkg::SFE_IDLE) && (state_next == sfe_pkg::SFE_RUN);

	wire [`SFE_FREQ_W-1:0] freq_next =
		start   ? START_FREQ :
		do_step ? freq_reg + DELTA_FREQ : freq_reg;
	wire [INTERVAL_W-1:0] tmr_next =
		(start || do_step) ? INTERVAL_CYCLES :
		(!tmr_done && run_en) ? tmr_reg - 1'b1 : tmr_reg;
	wire [11:0] step_next = start ? 12'h000 : do_step ? step_reg + 12'h001 : step_reg;
	wire active_next = scan_kill ? 1'b0 : start ? 1'b1 : active_reg;
	// Phase accumulator: fout = fclk * freq / 2^width
	wire [`SFE_PHASE_W-1:0] phase_next =
		!active_next ? '0 : (run_en ? phase_reg + freq_reg : phase_reg);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_reg   <= `SFE_CTRL_RESET;
			state_reg  <= sfe_pkg::SFE_IDLE;
			freq_reg   <= `SFE_FREQ_RESET;
			step_reg   <= 12'h000;
			tmr_reg    <= '0;
			phase_reg  <= '0;
			active_reg <= 1'b0;
		end else begin
			ctrl_reg   <= ctrl_next;
			state_reg  <= state_next;
			freq_reg   <= freq_next;
			step_reg   <= step_next;
			tmr_reg    <= tmr_next;
			phase_reg  <= phase_next;
			active_reg <= active_next;
		end
	end

	// Output datapath; DAC sits at midscale until a scan starts
	wire [`SFE_DAC_W-1:0] dac_code =
		active_reg ? phase_reg[`SFE_PHASE_W-1 -: `SFE_DAC_W] : `SFE_DAC_MID;
	wire sync_evt = ctrl.sync_select ? do_finish : do_step;
	wire sync_next = ctrl.sync_pin_enable & sync_evt;
	wire sign_next = ctrl.sign_pin_enable & ~dac_code[`SFE_DAC_W-1];
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			SCAN_SYNC_OUT <= 1'b0;
			SIGN_BIT_OUT  <= 1'b0;
			ANALOG_OUT    <= `SFE_DAC_MID;
			POWER_DOWN    <= 1'b0;
			CTRL_WORD     <= `SFE_CTRL_RESET;
			SCAN_STATE    <= 2'h0;
		end else begin
			SCAN_SYNC_OUT <= sync_next;
			SIGN_BIT_OUT  <= sign_next;
			ANALOG_OUT    <= dac_code;
			POWER_DOWN    <= stby_lvl_reg;
			CTRL_WORD     <= ctrl_reg;
			SCAN_STATE    <= state_reg;
		end
	end
endmodule : sfe_top
`default_nettype wire

// File: testbench/sfe_host_model.sv
// Purpose: host side of the three-wire serial link
// Assumes: shift clock idles high, runs only inside frames
// Notes: released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module sfe_host_model (
	output logic sclk,
	output logic frame_sync_n,
	output logic serial_data_in
);
	initial begin
		sclk = 1'h1;
		frame_sync_n = 1'h1;
		serial_data_in = 1'h0;
	end
	// Odd setup offset keeps the shift clock off the system clock grid
	task automatic send(input logic [15:0] w, input logic last);
		frame_sync_n = 1'h0;
		#21.3;
		for (int i = 15; i >= 0; i--) begin
			serial_data_in = w[i];
			#62.5 sclk = 1'h0;
			#62.5 sclk = 1'h1;
		end
		if (last) begin
			#21.3 frame_sync_n = 1'h1;
			serial_data_in = ~serial_data_in;
		end
	endtask : send
endmodule : sfe_host_model
`default_nettype wire

// File: testbench/sfe_top_asserts.sv
// Purpose: port checks for sfe_top
// Assumes: all checks on CLK_SYS
// Notes: latency windows follow the hand-over figures
`timescale 1ns/1ps
`default_nettype none
`include "sfe_defines.svh"
module sfe_top_asserts (
	input wire logic                   CLK_SYS,
	input wire logic                   RST_N,
	input wire logic                   SCAN_TRIGGER,
	input wire logic                   SCAN_ABORT,
	input wire logic                   STANDBY,
	input wire logic                   SCAN_SYNC_OUT,
	input wire logic                   SIGN_BIT_OUT,
	input wire logic [`SFE_DAC_W-1:0]  ANALOG_OUT,
	input wire logic                   POWER_DOWN,
	input wire logic [`SFE_CTRL_MSB:0] CTRL_WORD,
	input wire logic [1:0]             SCAN_STATE
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence s_start;
		$rose(SCAN_TRIGGER) && SCAN_STATE == 2'h0 && !STANDBY && !POWER_DOWN && !SCAN_ABORT;
	endsequence
	sequence s_abort;
		$rose(SCAN_ABORT) && !STANDBY && !POWER_DOWN;
	endsequence
	chk_trig_start: assert property (s_start |-> ##[2:8] SCAN_STATE == 2'h1)
		else $error("scan did not start after trigger");
	chk_abort_idle: assert property (s_abort |-> ##[1:8] SCAN_STATE == 2'h0)
		else $error("abort did not return scan to idle");
	chk_idle_mid: assert property (SCAN_STATE == 2'h0 && $past(SCAN_STATE) == 2'h0
		|-> ANALOG_OUT == `SFE_DAC_MID)
		else $error("idle output not midscale");
	chk_ctrl_reset: assert property ($past(CTRL_WORD) != CTRL_WORD |-> ##[0:2] SCAN_STATE == 2'h0)
		else $error("control write did not reset scan");
	chk_done_exit: assert property ($past(SCAN_STATE) == 2'h2 |-> SCAN_STATE inside {2'h2, 2'h0})
		else $error("finished scan resumed");
	chk_sync_off: assert property (!CTRL_WORD[2] && !$past(CTRL_WORD[2]) |-> !SCAN_SYNC_OUT)
		else $error("sync pin active while disabled");
	chk_sign_gate: assert property (!CTRL_WORD[3] && !$past(CTRL_WORD[3]) |-> !SIGN_BIT_OUT)
		else $error("sign pin active while disabled");
	chk_sign_inv: assert property (CTRL_WORD[3] && $past(CTRL_WORD[3])
		|-> SIGN_BIT_OUT == !ANALOG_OUT[`SFE_DAC_W-1])
		else $error("sign pin not inverted code top bit");
	chk_standby_pd: assert property (STANDBY [*6] |-> POWER_DOWN)
		else $error("standby did not power down");
	chk_standby_hold: assert property (POWER_DOWN && $past(POWER_DOWN)
		|-> $stable(SCAN_STATE) && $stable(ANALOG_OUT))
		else $error("scan moved in standby");
endmodule : sfe_top_asserts
bind sfe_top sfe_top_asserts i_sfe_top_asserts (.CLK_SYS, .RST_N, .SCAN_TRIGGER, .SCAN_ABORT,
	.STANDBY, .SCAN_SYNC_OUT, .SIGN_BIT_OUT, .ANALOG_OUT, .POWER_DOWN, .CTRL_WORD, .SCAN_STATE);
`default_nettype wire

// File: testbench/sfe_top_bench.sv
// Purpose: self-checking bench for sfe_top
// Assumes: host model drives the serial link
// Notes: interval width shortened to keep scans brief
`timescale 1ns/1ps
`default_nettype none
`include "sfe_defines.svh"
module sfe_top_bench;
	typedef struct packed {logic [15:0] word; logic [11:0] exp;} sfe_row_t;
	logic       clk_sys, rst_n, trg, abt, stby, sclk, fs_n, sdi, sync_out, sign_out, pwr_dn;
	logic [9:0] dac;
	logic [11:0] ctrl;
	logic [1:0] state;
	int         errors, checks_done, pulses;
	// The refused row must leave the previous value in place
	sfe_row_t   rows [4] = '{'{16'h0001, 12'h001}, '{16'h000E, 12'h00E},
		'{16'h5ABC, 12'h00E}, '{16'h0F00, 12'hF00}};
	sfe_top #(.INTERVAL_W(8)) i_sfe_top (.CLK_SYS(clk_sys), .RST_N(rst_n), .SCLK_LINK(sclk),
		.FRAME_SYNC_N(fs_n), .SERIAL_DATA_IN(sdi), .SCAN_TRIGGER(trg), .SCAN_ABORT(abt),
		.STANDBY(stby), .START_FREQ(24'h001000), .DELTA_FREQ(24'h000800), .NUM_INCR(12'h002),
		.INTERVAL_CYCLES(8'h04), .SCAN_SYNC_OUT(sync_out), .SIGN_BIT_OUT(sign_out),
		.ANALOG_OUT(dac), .POWER_DOWN(pwr_dn), .CTRL_WORD(ctrl), .SCAN_STATE(state));
	sfe_host_model i_sfe_host_model (.sclk(sclk), .frame_sync_n(fs_n), .serial_data_in(sdi));
	initial begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (sync_out) pulses++;
	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic pulse(input logic ab);
		@(posedge clk_sys);
		if (ab) abt <= 1'h1;
		else trg <= 1'h1;
		repeat (4) @(posedge clk_sys);
		abt <= 1'h0;
		trg <= 1'h0;
		repeat (12) @(posedge clk_sys);
	endtask : pulse
	task automatic wr(input logic [15:0] w);
		i_sfe_host_model.send(w, 1'h1);
		repeat (12) @(posedge clk_sys);
	endtask : wr
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict
	initial begin
		#300000;
		errors++;
		print_verdict;
	end
	initial begin
		{rst_n, trg, abt, stby} = 4'h0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'h1;
		@(posedge clk_sys);
		chk("dac", 12'(dac), 12'h200);
		foreach (rows[i]) begin
			wr(rows[i].word);
			chk("ctrl", ctrl, rows[i].exp);
			chk("dac", 12'(dac), 12'h200);
		end
		i_sfe_host_model.send(16'h0008, 1'h0);
		i_sfe_host_model.send(16'h0004, 1'h1);
		repeat (12) @(posedge clk_sys);
		chk("ctrl", ctrl, 12'h004);
		wr(16'h0007);
		pulses = 0;
		pulse(1'h0);
		repeat (80) @(posedge clk_sys);
		chk("state", 12'(state), 12'h002);
		chk("pulses", 12'(pulses), 12'h001);
		chk("sign", 12'(sign_out), 12'h000);
		wr(16'h000C);
		pulses = 0;
		pulse(1'h0);
		chk("state", 12'(state), 12'h001);
		chk("sign", 12'(sign_out), 12'(!dac[9]));
		repeat (2) pulse(1'h0);
		chk("state", 12'(state), 12'h001);
		pulse(1'h0);
		repeat (20) @(posedge clk_sys);
		chk("state", 12'(state), 12'h002);
		chk("pulses", 12'(pulses), 12'h002);
		wr(16'h0008);
		pulse(1'h0);
		pulse(1'h1);
		chk("state", 12'(state), 12'h000);
		chk("dac", 12'(dac), 12'h200);
		stby <= 1'h1;
		repeat (10) @(posedge clk_sys);
		chk("pwr", 12'(pwr_dn), 12'h001);
		pulse(1'h0);
		chk("state", 12'(state), 12'h000);
		stby <= 1'h0;
		repeat (10) @(posedge clk_sys);
		chk("pwr", 12'(pwr_dn), 12'h000);
		print_verdict;
	end
endmodule : sfe_top_bench
`default_nettype wire
